// File: core/shed_pkg.sv
// constants, field layouts and types shared by the phase shedding and report control block
`default_nettype none
package shed_pkg;

  // ****************************************
  // register command codes
  // ****************************************
  localparam logic [7:0] ADDR_LOW_PHASE = 8'haa;
  localparam logic [7:0] ADDR_AUTO_SHED = 8'hab;
  localparam logic [7:0] ADDR_REPORT    = 8'had;

  // ****************************************
  // field layouts, masks and reset values
  // ****************************************
  localparam int LP_WARM_LSB   = 4;
  localparam int LP_COLD_LSB   = 0;
  localparam int AS_RESUME_LSB = 10;
  localparam int AS_UV_BIT     = 9;
  localparam int AS_INTV_BIT   = 8;
  localparam int AS_OCUR_BIT   = 7;
  localparam int AS_DROP_LSB   = 1;
  localparam int AS_MODE_BIT   = 0;
  localparam int RC_MODE_LSB   = 10;
  localparam int RC_WIN_LSB    = 0;

  localparam logic [15:0] LP_MASK  = 16'h00ff;
  localparam logic [15:0] AS_MASK  = 16'hffff;
  localparam logic [15:0] RC_MASK  = 16'h0fff;
  localparam logic [15:0] LP_RESET = 16'h0000;
  localparam logic [15:0] AS_RESET = 16'h0000;
  localparam logic [15:0] RC_RESET = 16'h0000;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS          = 10;
  localparam int RESUME_STEP_NS  = 20000;
  localparam int DROP_STEP_NS    = 1000;
  localparam int WIN_STEP_NS     = 100000;
  localparam int UV_MARGIN_MV    = 25;
  localparam int RESUME_STEP_CYC = (RESUME_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int DROP_STEP_CYC   = (DROP_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WIN_STEP_CYC    = (WIN_STEP_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    REP_AVG   = 2'b00,
    REP_RT    = 2'b01,
    REP_LATCH = 2'b10
  } rep_mode_e;

  typedef enum logic [2:0] {
    KIND_VIN  = 3'h0,
    KIND_VOUT = 3'h1,
    KIND_IOUT = 3'h2,
    KIND_TEMP = 3'h3,
    KIND_EFF  = 3'h4,
    KIND_POUT = 3'h5,
    KIND_PIN  = 3'h6
  } tele_kind_e;

  typedef enum logic [1:0] {
    ST_FULL = 2'b00,
    ST_SHED = 2'b01,
    ST_HOLD = 2'b11
  } shed_st_e;

  // mode actually used for a reading; temperature is always real-time, other unsupported modes fall back to averaging
  function automatic rep_mode_e eff_mode(input logic [2:0] kind, input logic [1:0] field);
    rep_mode_e m;
    m = field[1] ? REP_LATCH : (field[0] ? REP_RT : REP_AVG);
    if (kind == KIND_TEMP) begin
      m = REP_RT;
    end else if ((kind == KIND_VIN || kind == KIND_VOUT) && m == REP_LATCH) begin
      m = REP_AVG;
    end else if (kind > KIND_TEMP && m == REP_RT) begin
      m = REP_AVG;
    end
    return m;
  endfunction

endpackage
`default_nettype wire

// File: core/step_timer.sv
// countdown of a programmed number of fixed-length steps, one done pulse at the end
`timescale 1ns/1ps
`default_nettype none
module step_timer #(
  parameter int STEP_CYC = 100,
  parameter int CNT_W    = 6
) (
  input  wire logic             clk,   // core clock
  input  wire logic             srst,  // synchronous reset
  input  wire logic             start, // pulse, (re)loads the count
  input  wire logic [CNT_W-1:0] steps, // number of steps to wait
  output logic                  busy,  // counting
  output logic                  done   // one-cycle pulse at expiry
);
  localparam int PW = $clog2(STEP_CYC) + 1;

  typedef struct packed {
    logic [PW-1:0]    pre;
    logic [CNT_W-1:0] left;
    logic             busy;
    logic             done;
  } tmr_s;

  tmr_s s_r;
  tmr_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (start) begin
      s_nxt.busy = 1'b1;
      s_nxt.left = steps;
      s_nxt.pre  = '0;
    end else if (s_r.busy) begin
      if (s_r.left == '0) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else if (s_r.pre == PW'(STEP_CYC - 1)) begin
        s_nxt.pre  = '0;
        s_nxt.left = s_r.left - 1'b1;
      end else begin
        s_nxt.pre = s_r.pre + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = s_r.busy;
  assign done = s_r.done;
endmodule
`default_nettype wire

// File: core/tele_avg.sv
// running window averager for one telemetry stream
`timescale 1ns/1ps
`default_nettype none
module tele_avg #(
  parameter int STEP_CYC = 10000,
  parameter int WIN_W    = 10,
  parameter int DW       = 16
) (
  input  wire logic             clk,          // core clock
  input  wire logic             srst,         // synchronous reset
  input  wire logic             restart,      // pulse, starts a fresh window
  input  wire logic [WIN_W-1:0] win_steps,    // window length in steps
  input  wire logic             sample_valid, // new sample present
  input  wire logic [DW-1:0]    sample_data,  // sample value
  output logic [DW-1:0]         avg_data,     // last window average
  output logic                  avg_valid     // pulse when avg_data updates
);
  localparam int PW = $clog2(STEP_CYC) + 1;
  localparam int CW = 24;

  typedef struct packed {
    logic [PW-1:0]      pre;
    logic [WIN_W-1:0]   steps;
    logic [DW+CW-1:0]   sum;
    logic [CW-1:0]      cnt;
    logic [DW-1:0]      avg;
    logic               valid;
  } avg_s;

  avg_s s_r;
  avg_s s_nxt;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.valid = 1'b0;
    if (sample_valid) begin
      s_nxt.sum = s_r.sum + {{CW{1'b0}}, sample_data};
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
    if (restart) begin
      s_nxt.pre   = '0;
      s_nxt.steps = '0;
      s_nxt.sum   = '0;
      s_nxt.cnt   = '0;
    end else if (s_r.pre == PW'(STEP_CYC - 1)) begin
      s_nxt.pre = '0;
      // a zero window behaves as one step so the average never freezes
      if (s_r.steps + 1'b1 >= win_steps) begin
        s_nxt.steps = '0;
        if (s_nxt.cnt != '0) begin
          s_nxt.avg   = DW'(s_nxt.sum / s_nxt.cnt);
          s_nxt.valid = 1'b1;
        end
        s_nxt.sum = '0;
        s_nxt.cnt = '0;
      end else begin
        s_nxt.steps = s_r.steps + 1'b1;
      end
    end else begin
      s_nxt.pre = s_r.pre + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avg_data  = s_r.avg;
  assign avg_valid = s_r.valid;
endmodule
`default_nettype wire

// File: core/phase_shed_and_report_ctrl.sv
// phase count selection, automatic shedding control and telemetry report modes
//
// Overview of operation
// R1 - low-state count register: upper byte ignores writes and reads zero
// R2 - power state low on warm boot runs the warm phase count
// R3 - first boot after reset is cold and uses the cold phase count
// R4 - after undervoltage or overcurrent exit, wait resume delay (20 us steps)
// R5 - undervoltage exit enable set: feedback 25 mV low forces full phases
// R6 - interval exit enable set: short pulse interval forces full phases
// R7 - overcurrent exit enable: valley limit at one phase forces full phases
// R8 - sequential drop spaces phase removals by the interval field, 1 us steps
// R9 - drop mode 0 drops together, 1 drops one at a time
// R10 - report mode 00 average, 01 real-time, 1x latch
// R11 - each reading uses only report modes it supports
// R12 - averaging window is the 10-bit field in 100 us steps
// R13 - drop after current stays in window for the check count, else restart
// R14 - latched results hold until the next latch command
`timescale 1ns/1ps
`default_nettype none
module phase_shed_and_report_ctrl #(
  parameter int          WIN_STEP_CYC = shed_pkg::WIN_STEP_CYC,
  parameter logic [3:0]  MAX_PHASES   = 4'h6
) (
  input  wire logic        clk,                // core clock, 100 MHz
  input  wire logic        srst,               // synchronous reset, power-on
  input  wire logic        reg_wr,             // register write strobe
  input  wire logic        reg_rd,             // register read strobe
  input  wire logic [7:0]  reg_addr,           // command code
  input  wire logic [15:0] reg_wdata,          // write data
  output logic [15:0]      reg_rdata,          // read data, next cycle
  input  wire logic        power_state_input,  // low selects low-phase mode
  input  wire logic        boot_start,         // pulse at each power-up
  input  wire logic        auto_shedding,      // automatic shedding enabled
  input  wire logic [3:0]  shed_target,        // phase count to shed down to
  input  wire logic        in_drop_window,     // current inside drop window
  input  wire logic [6:0]  drop_check_count,   // consecutive counts before drop
  input  wire logic        fb_below_ref_25mv,  // feedback below reference - 25 mV
  input  wire logic        pulse_interval_short, // interval under its threshold
  input  wire logic        valley_limit_ph1,   // phase one valley current limit
  output logic [3:0]       active_phases,      // phases running
  output logic             full_phase,         // all phases running
  output logic             shedding,           // shed state active
  output logic             boot_is_warm,       // current boot is warm
  input  wire logic        sample_valid,       // telemetry sample strobe
  input  wire logic [15:0] sample_data,        // telemetry sample
  input  wire logic [2:0]  report_kind,        // which reading is reported
  input  wire logic        latch_cmd,          // pulse, starts a latch window
  output logic [15:0]      report_data,        // reported value
  output logic             latch_pending       // latch window running
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0]        lp;
    logic [15:0]        as;
    logic [15:0]        rc;
    logic [15:0]        rdata;
    logic               booted;
    logic               warm;
    shed_pkg::shed_st_e st;
    logic [3:0]         active;
    logic [3:0]         target;
    logic [6:0]         chk;
    logic               resume_go;
    logic               drop_go;
    logic [15:0]        rt_val;
    logic [15:0]        latched;
    logic               latch_wait;
    logic [15:0]        report;
  } ctrl_s;

  ctrl_s s_r;
  ctrl_s s_nxt;

  logic        resume_done;
  logic        drop_done;
  logic [15:0] avg_val;
  logic        avg_valid;
  logic [3:0]  low_cnt;
  logic        exit_uv;
  logic        exit_intv;
  logic        exit_ocur;
  logic        seq_mode;
  shed_pkg::rep_mode_e mode_used;

  function automatic logic [3:0] clamp_ph(input logic [3:0] n);
    logic [3:0] r;
    r = n;
    if (n > MAX_PHASES) begin
      r = MAX_PHASES;
    end else if (n == 4'h0) begin
      r = 4'h1;
    end
    return r;
  endfunction

  // ****************************************
  // timers and averager
  // ****************************************
  step_timer #(
    .STEP_CYC (shed_pkg::RESUME_STEP_CYC),
    .CNT_W    (6)
  ) u_resume (
    .clk   (clk),
    .srst  (srst),
    .start (s_r.resume_go),
    .steps (s_r.as[shed_pkg::AS_RESUME_LSB +: 6]), // R4
    .busy  (),
    .done  (resume_done)
  );

  step_timer #(
    .STEP_CYC (shed_pkg::DROP_STEP_CYC),
    .CNT_W    (6)
  ) u_drop (
    .clk   (clk),
    .srst  (srst),
    .start (s_r.drop_go),
    .steps (s_r.as[shed_pkg::AS_DROP_LSB +: 6]), // R8
    .busy  (),
    .done  (drop_done)
  );

  tele_avg #(
    .STEP_CYC (WIN_STEP_CYC),
    .WIN_W    (10),
    .DW       (16)
  ) u_avg (
    .clk          (clk),
    .srst         (srst),
    .restart      (latch_cmd),
    .win_steps    (s_r.rc[shed_pkg::RC_WIN_LSB +: 10]), // R12
    .sample_valid (sample_valid),
    .sample_data  (sample_data),
    .avg_data     (avg_val),
    .avg_valid    (avg_valid)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    low_cnt   = clamp_ph(s_r.warm ? s_r.lp[shed_pkg::LP_WARM_LSB +: 4]        // R2
                                  : s_r.lp[shed_pkg::LP_COLD_LSB +: 4]);      // R3
    exit_uv   = s_r.as[shed_pkg::AS_UV_BIT] && fb_below_ref_25mv;             // R5
    exit_intv = s_r.as[shed_pkg::AS_INTV_BIT] && pulse_interval_short;        // R6
    exit_ocur = s_r.as[shed_pkg::AS_OCUR_BIT] && (s_r.active == 4'h1)
                && valley_limit_ph1;                                          // R7
    seq_mode  = s_r.as[shed_pkg::AS_MODE_BIT];
    mode_used = shed_pkg::eff_mode(report_kind, s_r.rc[shed_pkg::RC_MODE_LSB +: 2]); // R11

    s_nxt           = s_r;
    s_nxt.resume_go = 1'b0;
    s_nxt.drop_go   = 1'b0;

    if (reg_wr) begin
      if (reg_addr == shed_pkg::ADDR_LOW_PHASE) begin
        s_nxt.lp = reg_wdata & shed_pkg::LP_MASK; // R1
      end else if (reg_addr == shed_pkg::ADDR_AUTO_SHED) begin
        s_nxt.as = reg_wdata & shed_pkg::AS_MASK;
      end else if (reg_addr == shed_pkg::ADDR_REPORT) begin
        s_nxt.rc = reg_wdata & shed_pkg::RC_MASK;
      end
    end
    if (reg_rd) begin
      if (reg_addr == shed_pkg::ADDR_LOW_PHASE) begin
        s_nxt.rdata = s_r.lp & shed_pkg::LP_MASK; // R1
      end else if (reg_addr == shed_pkg::ADDR_AUTO_SHED) begin
        s_nxt.rdata = s_r.as;
      end else if (reg_addr == shed_pkg::ADDR_REPORT) begin
        s_nxt.rdata = s_r.rc & shed_pkg::RC_MASK;
      end else begin
        s_nxt.rdata = 16'h0000;
      end
    end

    // the first power-up after reset is cold, every later one warm
    if (boot_start) begin
      s_nxt.booted = 1'b1;
      s_nxt.warm   = s_r.booted; // R3
    end

    if (!power_state_input) begin
      s_nxt.st     = shed_pkg::ST_FULL;
      s_nxt.active = low_cnt; // R2
      s_nxt.chk    = 7'h00;
    end else if (!auto_shedding) begin
      s_nxt.st     = shed_pkg::ST_FULL;
      s_nxt.active = MAX_PHASES;
      s_nxt.chk    = 7'h00;
    end else begin
      case (s_r.st)
        shed_pkg::ST_FULL: begin
          s_nxt.active = MAX_PHASES;
          if (!in_drop_window) begin
            s_nxt.chk = 7'h00; // R13
          end else if (s_r.chk + 7'h01 >= drop_check_count
                       && clamp_ph(shed_target) < MAX_PHASES) begin
            s_nxt.chk    = 7'h00; // R13
            s_nxt.st     = shed_pkg::ST_SHED;
            s_nxt.target = clamp_ph(shed_target);
            if (seq_mode) begin
              // first phase goes at once, the rest wait out the interval
              s_nxt.active  = MAX_PHASES - 4'h1; // R8
              s_nxt.drop_go = (MAX_PHASES - 4'h1) > clamp_ph(shed_target);
            end else begin
              s_nxt.active = clamp_ph(shed_target); // R9
            end
          end else begin
            s_nxt.chk = s_r.chk + 7'h01;
          end
        end
        shed_pkg::ST_SHED: begin
          if (exit_uv || exit_ocur) begin
            s_nxt.st        = shed_pkg::ST_HOLD;
            s_nxt.active    = MAX_PHASES; // R5 R7
            s_nxt.resume_go = 1'b1;       // R4
          end else if (exit_intv) begin
            s_nxt.st     = shed_pkg::ST_FULL;
            s_nxt.active = MAX_PHASES; // R6
          end else if (!seq_mode) begin
            s_nxt.active = s_r.target; // R9
          end else if (drop_done && s_r.active > s_r.target) begin
            s_nxt.active  = s_r.active - 4'h1;               // R8
            s_nxt.drop_go = (s_r.active - 4'h1) > s_r.target; // R8
          end
        end
        shed_pkg::ST_HOLD: begin
          s_nxt.active = MAX_PHASES;
          s_nxt.chk    = 7'h00;
          if (resume_done) begin
            s_nxt.st = shed_pkg::ST_FULL; // R4
          end
        end
        default: begin
          s_nxt.st     = shed_pkg::ST_FULL;
          s_nxt.active = MAX_PHASES;
        end
      endcase
    end

    // telemetry
    if (sample_valid) begin
      s_nxt.rt_val = sample_data;
    end
    // a new command wins over a window ending in the same cycle
    if (latch_cmd) begin
      s_nxt.latch_wait = 1'b1; // R14
    end else if (avg_valid && s_r.latch_wait) begin
      s_nxt.latched    = avg_val; // R10
      s_nxt.latch_wait = 1'b0;
    end
    case (mode_used)
      shed_pkg::REP_RT:    s_nxt.report = s_r.rt_val;  // R10
      shed_pkg::REP_LATCH: s_nxt.report = s_r.latched; // R10
      default:             s_nxt.report = avg_val;     // R10
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r    <= '0;
      s_r.lp <= shed_pkg::LP_RESET;
      s_r.as <= shed_pkg::AS_RESET;
      s_r.rc <= shed_pkg::RC_RESET;
      s_r.active <= MAX_PHASES;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata     = s_r.rdata;
  assign active_phases = s_r.active;
  assign full_phase    = (s_r.active == MAX_PHASES);
  assign shedding      = (s_r.st == shed_pkg::ST_SHED);
  assign boot_is_warm  = s_r.warm;
  assign report_data   = s_r.report;
  assign latch_pending = s_r.latch_wait;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_RSVD_ZERO: assert property ( // R1
    reg_rd && reg_addr == shed_pkg::ADDR_LOW_PHASE |=> reg_rdata[15:8] == 8'h00)
    else $error("reserved byte of low-state count not zero");
  AST_WARM_COUNT: assert property ( // R2
    !power_state_input && s_r.warm |=> active_phases == clamp_ph($past(s_r.lp[7:4])))
    else $error("warm boot low-phase count not applied");
  AST_COLD_COUNT: assert property ( // R3
    !power_state_input && !s_r.warm |=> active_phases == clamp_ph($past(s_r.lp[3:0])))
    else $error("cold boot low-phase count not applied");
  AST_RESUME_WAIT: assert property ( // R4
    s_r.st == shed_pkg::ST_HOLD && !resume_done && power_state_input && auto_shedding
    |=> s_r.st == shed_pkg::ST_HOLD)
    else $error("shedding resumed before the delay");
  AST_UV_EXIT: assert property ( // R5
    shedding && power_state_input && auto_shedding && exit_uv
    |=> full_phase && s_r.st == shed_pkg::ST_HOLD)
    else $error("undervoltage exit not taken");
  AST_INTV_EXIT: assert property ( // R6
    shedding && power_state_input && auto_shedding && exit_intv |=> full_phase)
    else $error("interval exit not taken");
  AST_OCUR_EXIT: assert property ( // R7
    shedding && power_state_input && auto_shedding && exit_ocur |=> ##[0:2] full_phase)
    else $error("overcurrent exit not taken");
  AST_SEQ_STEP: assert property ( // R8
    shedding && seq_mode && $stable(shedding) && active_phases < $past(active_phases)
    |-> $past(active_phases) - active_phases == 4'h1)
    else $error("sequential drop removed more than one phase");
  AST_TOGETHER: assert property ( // R9
    shedding && !seq_mode && $past(shedding) && $past(!seq_mode)
    |-> active_phases == s_r.target)
    else $error("together drop not at target");
  AST_CHECK_COUNT: assert property ( // R13
    s_r.st == shed_pkg::ST_FULL && !in_drop_window |=> s_r.chk == 7'h00)
    else $error("drop check count not restarted");
  AST_TEMP_RT: assert property ( // R11
    report_kind == shed_pkg::KIND_TEMP |=> report_data == $past(s_r.rt_val))
    else $error("temperature not reported in real time");
  AST_LATCH_HOLD: assert property ( // R14
    !$past(avg_valid && s_r.latch_wait && !latch_cmd) |-> $stable(s_r.latched))
    else $error("latched result changed without a window end");

  COV_SHED: cover property (s_r.st == shed_pkg::ST_FULL ##1 shedding);
  COV_HOLD: cover property (s_r.st == shed_pkg::ST_HOLD ##1 s_r.st == shed_pkg::ST_FULL);
  COV_SEQ: cover property (shedding && seq_mode && drop_done);
  COV_LATCH: cover property (latch_pending ##1 !latch_pending);
endmodule
`default_nettype wire

// File: sim/host_model.sv
// host side of the register port: one-cycle write and read strobes
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        clk,   // core clock
  output logic             wr,    // write strobe
  output logic             rd,    // read strobe
  output logic [7:0]       addr,  // command code
  output logic [15:0]      wdata, // write data
  input  wire logic [15:0] rdata  // read data
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
  end

  task automatic put(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    // released lines show garbage so a late sample cannot pass
    addr = ~a;
    wdata = ~d;
  endtask

  task automatic get(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    addr = ~a;
    @(posedge clk);
    #1;
    d = rdata;
  endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for phase shedding and report control
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, report_data, rv;
  logic [15:0] sample_data = 16'h0000;
  logic power_state_input = 1'b1, boot_start = 1'b0, auto_shedding = 1'b0;
  logic in_drop_window = 1'b0, fb_below_ref_25mv = 1'b0, latch_cmd = 1'b0;
  logic pulse_interval_short = 1'b0, valley_limit_ph1 = 1'b0, sample_valid = 1'b1;
  logic [3:0] shed_target = 4'h2, active_phases;
  logic [6:0] drop_check_count = 7'h04;
  logic [2:0] report_kind = 3'h3;
  logic full_phase, shedding, boot_is_warm, latch_pending;
  logic [7:0] ra[4] = '{shed_pkg::ADDR_LOW_PHASE, shed_pkg::ADDR_AUTO_SHED,
                        shed_pkg::ADDR_REPORT, 8'h10};
  logic [15:0] rm[4] = '{16'h00ff, 16'hffff, 16'h0fff, 16'h0000};
  int bad_count = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  // short window step keeps the averaging tests brief
  phase_shed_and_report_ctrl #(.WIN_STEP_CYC(10)) dut_u (
    .clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .power_state_input, .boot_start, .auto_shedding, .shed_target,
    .in_drop_window, .drop_check_count, .fb_below_ref_25mv,
    .pulse_interval_short, .valley_limit_ph1, .active_phases, .full_phase,
    .shedding, .boot_is_warm, .sample_valid, .sample_data, .report_kind,
    .latch_cmd, .report_data, .latch_pending);
  host_model host_u (.clk(clk), .wr(reg_wr), .rd(reg_rd), .addr(reg_addr),
    .wdata(reg_wdata), .rdata(reg_rdata));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // sel 0 watches active_phases, 1 watches report_data; lo is the earliest cycle
  task automatic wait_for(input bit sel, input logic [15:0] exp, input int lo, input int hi);
    int i;
    i = 0;
    while ((sel ? report_data : {12'h0, active_phases}) !== exp && i < hi) begin
      cyc(1);
      i++;
    end
    cmp(sel ? report_data : {12'h0, active_phases}, exp);
    cmp({15'h0, i >= lo}, 16'h0001);
    // only a value still wrong at the bound is a timeout
    if ((sel ? report_data : {12'h0, active_phases}) !== exp) begin
      report_and_stop();
    end
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    cyc(8);
    srst = 1'b0;
    for (int k = 0; k < 4; k++) begin
      host_u.get(ra[k], rv);
      cmp(rv, 16'h0000);
      host_u.put(ra[k], 16'hffff);
      host_u.get(ra[k], rv);
      cmp(rv, rm[k]);
    end
    $display("test registers done");
    host_u.put(ra[0], 16'h0042);
    power_state_input = 1'b0;
    for (int b = 0; b < 2; b++) begin
      boot_start = 1'b1;
      cyc(1);
      boot_start = 1'b0;
      wait_for(1'b0, b ? 16'h4 : 16'h2, b, 20);
      cmp({15'h0, boot_is_warm}, 16'(b));
    end
    power_state_input = 1'b1;
    wait_for(1'b0, 16'h6, 1, 20);
    $display("test boots done");
    host_u.put(ra[1], 16'h0000);
    auto_shedding = 1'b1;
    in_drop_window = 1'b1;
    cyc(2);
    in_drop_window = 1'b0;
    cyc(1);
    cmp({12'h0, active_phases}, 16'h0006);
    in_drop_window = 1'b1;
    wait_for(1'b0, 16'h2, 3, 10);
    cmp({14'h0, shedding, full_phase}, 16'h0002);
    host_u.put(ra[1], 16'h0600);
    fb_below_ref_25mv = 1'b1;
    wait_for(1'b0, 16'h6, 1, 3);
    cmp({14'h0, shedding, full_phase}, 16'h0001);
    fb_below_ref_25mv = 1'b0;
    wait_for(1'b0, 16'h2, 1990, 2100);
    host_u.put(ra[1], 16'h0400);
    fb_below_ref_25mv = 1'b1;
    cyc(20);
    cmp({12'h0, active_phases}, 16'h0002);
    fb_below_ref_25mv = 1'b0;
    host_u.put(ra[1], 16'h0100);
    pulse_interval_short = 1'b1;
    wait_for(1'b0, 16'h6, 1, 3);
    pulse_interval_short = 1'b0;
    shed_target = 4'h1;
    wait_for(1'b0, 16'h1, 4, 12);
    host_u.put(ra[1], 16'h0080);
    valley_limit_ph1 = 1'b1;
    wait_for(1'b0, 16'h6, 1, 3);
    valley_limit_ph1 = 1'b0;
    auto_shedding = 1'b0;
    wait_for(1'b0, 16'h6, 0, 10);
    host_u.put(ra[1], 16'h0005);
    shed_target = 4'h2;
    auto_shedding = 1'b1;
    wait_for(1'b0, 16'h5, 3, 10);
    wait_for(1'b0, 16'h4, 190, 215);
    $display("test shedding done");
    host_u.put(ra[2], 16'h0002);
    sample_data = 16'h1234;
    wait_for(1'b1, 16'h1234, 2, 5);
    report_kind = 3'h0;
    sample_data = 16'h5678;
    wait_for(1'b1, 16'h5678, 5, 50);
    host_u.put(ra[2], 16'h0402);
    sample_data = 16'h9abc;
    wait_for(1'b1, 16'h9abc, 2, 4);
    // a sample without its strobe must not reach the real-time value
    sample_valid = 1'b0;
    sample_data = 16'h5555;
    cyc(3);
    cmp(report_data, 16'h9abc);
    sample_valid = 1'b1;
    report_kind = 3'h4;
    sample_data = 16'h1111;
    wait_for(1'b1, 16'h1111, 5, 50);
    host_u.put(ra[2], 16'h0802);
    report_kind = 3'h2;
    sample_data = 16'h2222;
    latch_cmd = 1'b1;
    cyc(1);
    latch_cmd = 1'b0;
    cmp({15'h0, latch_pending}, 16'h0001);
    wait_for(1'b1, 16'h2222, 20, 50);
    cmp({15'h0, latch_pending}, 16'h0000);
    sample_data = 16'h3333;
    cyc(60);
    cmp(report_data, 16'h2222);
    $display("test telemetry done");
    report_and_stop();
  end
endmodule
`default_nettype wire
